// *** rtl/rmsb_bank.sv ***
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rmsb_bank (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // Events from the controller
    input wire rmsb_pkg::rmsb_event_type EVENTS,
    input wire logic [2:0] TX_STATE,
    input wire logic TAG_MODE,
    input wire logic [15:0] MAC_STATE,
    input wire logic HDATA_DONE,
    // Receive frame status
    input wire logic FRAME_DONE,
    input wire logic SRC_ADDR_MSB,
    input wire logic [2:0] RX_EAC_INDICATORS,
    output logic [31:0] RX_FRAME_STATUS,
    // Physical layer receive buses
    input wire logic [9:0] RX_BUS_A,
    input wire logic [9:0] RX_BUS_B,
    output logic [9:0] RX_SYMBOL,
    // Mode outputs
    output logic SINGLE_FRAME_RX_MODE,
    output logic SHORT_ADDR_SELECT,
    output logic SYMBOL_CONTROL_BIT,
    output logic SYNC_HOST_DMA_REQUEST,
    // Interrupt
    output logic IRQ
);
    // ------------------------------------------------
    // Decoding
    // ------------------------------------------------
    function automatic logic in_group(input logic [3:0] a, input logic [3:0] base);
        in_group = (a[3:2] == base[3:2]);
    endfunction

    logic [15:0] status [4];
    logic [15:0] enable [4];
    logic [15:0] set_vec [4];
    logic [15:0] clr_vec [4];
    logic [15:0] mode_one;
    logic [15:0] mode_two;
    logic [15:0] host_data_register;
    logic host_request_pending;
    logic [15:0] error_event_counter;
    logic [15:0] rx_frame_counter;
    logic [15:0] lost_frame_counter;
    logic [9:0] bus_a_s1, bus_a_s2, bus_b_s1, bus_b_s2;
    logic [15:0] next_rdata;

    wire wr_clear = REG_WR && in_group(REG_ADDR, rmsb_pkg::ADDR_CLEAR_BASE);
    wire wr_enable = REG_WR && in_group(REG_ADDR, rmsb_pkg::ADDR_ENABLE_BASE);
    wire rd_enable = in_group(REG_ADDR, rmsb_pkg::ADDR_ENABLE_BASE);
    wire [1:0] idx = REG_ADDR[1:0];
    wire hdata_access = (REG_WR || REG_RD) && (REG_ADDR == rmsb_pkg::ADDR_HDATA);
    wire rx_bus_select = mode_one[rmsb_pkg::MODE1_RXSEL];
    wire err_ovf = EVENTS.err_event && (error_event_counter == rmsb_pkg::CNT_MAX);
    wire frm_ovf = EVENTS.rx_frame && (rx_frame_counter == rmsb_pkg::CNT_MAX);
    wire lost_ovf = EVENTS.lost_frame && (lost_frame_counter == rmsb_pkg::CNT_MAX);
    wire trt_late = EVENTS.trt_expired && EVENTS.late_count_nz;
    wire trt_rec = EVENTS.trt_expired
        && (TX_STATE == rmsb_pkg::TX_T4 || TX_STATE == rmsb_pkg::TX_T5);

    // ------------------------------------------------
    // Event placement
    // ------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            set_vec[i] = 16'h0000;
        end
        set_vec[0][rmsb_pkg::S1HI_FEND +: 4] = EVENTS.tx_frame_end;
        set_vec[0][rmsb_pkg::S1HI_CHAIN +: 4] = EVENTS.tx_chain_end;
        set_vec[0][rmsb_pkg::S1HI_SFULL] = TAG_MODE && EVENTS.sync_full;
        set_vec[0][rmsb_pkg::S1HI_AFULL] = TAG_MODE && EVENTS.async_full;
        set_vec[0][rmsb_pkg::S1HI_ABORT] = TAG_MODE && EVENTS.tx_abort;
        set_vec[1][rmsb_pkg::S1LO_LOCK +: 4] = EVENTS.queue_lock;
        set_vec[1][rmsb_pkg::S1LO_UNDER +: 4] = EVENTS.tx_underrun;
        set_vec[2][rmsb_pkg::S2HI_RCOMP] = EVENTS.rx_flags[6];
        set_vec[2][rmsb_pkg::S2HI_RMT] = EVENTS.rx_flags[5];
        set_vec[2][rmsb_pkg::S2HI_RABT] = EVENTS.rx_flags[4];
        set_vec[2][rmsb_pkg::S2HI_RFULL] = EVENTS.rx_flags[3];
        set_vec[2][rmsb_pkg::S2HI_ROVR] = EVENTS.rx_flags[2];
        set_vec[2][rmsb_pkg::S2HI_RSNGL] = EVENTS.rx_flags[1];
        set_vec[2][rmsb_pkg::S2HI_RFCOV] = EVENTS.rx_flags[0];
        set_vec[2][rmsb_pkg::S2HI_SFERR] = EVENTS.recovery_flags[5];
        set_vec[2][rmsb_pkg::S2HI_MYCLM] = EVENTS.recovery_flags[4];
        set_vec[2][rmsb_pkg::S2HI_HICLM] = EVENTS.recovery_flags[3];
        set_vec[2][rmsb_pkg::S2HI_LOCLM] = EVENTS.recovery_flags[2];
        set_vec[2][rmsb_pkg::S2HI_MYBEC] = EVENTS.recovery_flags[1];
        set_vec[2][rmsb_pkg::S2HI_OTBEC] = EVENTS.recovery_flags[0];
        set_vec[3][rmsb_pkg::S2LO_RNGOP] = EVENTS.ring_flags[7];
        set_vec[3][rmsb_pkg::S2LO_MULTDA] = EVENTS.ring_flags[6];
        set_vec[3][rmsb_pkg::S2LO_TKERR] = EVENTS.ring_flags[5];
        set_vec[3][rmsb_pkg::S2LO_TKISS] = EVENTS.ring_flags[4];
        set_vec[3][rmsb_pkg::S2LO_VALIDTX] = EVENTS.ring_flags[3];
        set_vec[3][rmsb_pkg::S2LO_MISS] = EVENTS.ring_flags[2];
        set_vec[3][rmsb_pkg::S2LO_PHYINV] = EVENTS.ring_flags[1];
        set_vec[3][rmsb_pkg::S2LO_SIFG] = EVENTS.ring_flags[0];
        set_vec[3][rmsb_pkg::S2LO_ERRC] = err_ovf;
        set_vec[3][rmsb_pkg::S2LO_FRMC] = frm_ovf;
        set_vec[3][rmsb_pkg::S2LO_LOST] = lost_ovf;
        set_vec[3][rmsb_pkg::S2LO_ROTLATE] = trt_late;
        set_vec[3][rmsb_pkg::S2LO_ROTREC] = trt_rec;
    end

    // ------------------------------------------------
    // Sticky status halves
    // ------------------------------------------------
    // four separately addressed halves
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_half
            assign clr_vec[g] = (wr_clear && idx == 2'(g)) ? REG_WDATA : 16'h0000;
            always_ff @(posedge CLK) begin
                if (RST) begin
                    status[g] <= 16'h0000;
                    enable[g] <= 16'h0000;
                end else begin
                    status[g] <= (status[g] & ~clr_vec[g]) | set_vec[g];
                    if (wr_enable && idx == 2'(g)) begin
                        enable[g] <= REG_WDATA;
                    end
                end
            end
        end
    endgenerate

    wire irq_any = |(status[0] & enable[0]) || |(status[1] & enable[1])
        || |(status[2] & enable[2]) || |(status[3] & enable[3]);
    assign IRQ = irq_any;

    // ------------------------------------------------
    // Counters, modes, host data
    // ------------------------------------------------
    // Counters wrap; only the overflow flag survives
    always_ff @(posedge CLK) begin
        if (RST) begin
            error_event_counter <= 16'h0000;
            rx_frame_counter <= 16'h0000;
            lost_frame_counter <= 16'h0000;
        end else begin
            error_event_counter <= error_event_counter + 16'(EVENTS.err_event);
            rx_frame_counter <= rx_frame_counter + 16'(EVENTS.rx_frame);
            lost_frame_counter <= lost_frame_counter + 16'(EVENTS.lost_frame);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_one <= rmsb_pkg::MODE1_RESET;
            mode_two <= rmsb_pkg::MODE2_RESET;
            host_data_register <= 16'h0000;
        end else begin
            if (REG_WR && REG_ADDR == rmsb_pkg::ADDR_MODE1) begin
                mode_one <= REG_WDATA;
            end
            if (REG_WR && REG_ADDR == rmsb_pkg::ADDR_MODE2) begin
                mode_two <= REG_WDATA;
            end
            if (REG_WR && REG_ADDR == rmsb_pkg::ADDR_HDATA) begin
                host_data_register <= REG_WDATA;
            end
        end
    end
    assign SINGLE_FRAME_RX_MODE = mode_one[rmsb_pkg::MODE1_SNGL];
    assign SHORT_ADDR_SELECT = mode_one[rmsb_pkg::MODE1_SHORTA];
    assign SYMBOL_CONTROL_BIT = mode_two[rmsb_pkg::MODE2_SYMBOL_CONTROL_BIT];
    assign SYNC_HOST_DMA_REQUEST = mode_two[rmsb_pkg::MODE2_SYNC_HOST_DMA_REQUEST];

    // pending until done; new access wins
    always_ff @(posedge CLK) begin
        if (RST) begin
            host_request_pending <= 1'b0;
        end else begin
            host_request_pending <= hdata_access || (host_request_pending && !HDATA_DONE);
        end
    end

    // ------------------------------------------------
    // Receive path
    // ------------------------------------------------
    // Pins cross in through two flops
    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_a_s1 <= 10'h000;
            bus_a_s2 <= 10'h000;
            bus_b_s1 <= 10'h000;
            bus_b_s2 <= 10'h000;
            RX_SYMBOL <= 10'h000;
        end else begin
            bus_a_s1 <= RX_BUS_A;
            bus_a_s2 <= bus_a_s1;
            bus_b_s1 <= RX_BUS_B;
            bus_b_s2 <= bus_b_s1;
            RX_SYMBOL <= rx_bus_select ? bus_a_s2 : bus_b_s2;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RX_FRAME_STATUS <= 32'h00000000;
        end else if (FRAME_DONE) begin
            RX_FRAME_STATUS <= 32'h00000000;
            RX_FRAME_STATUS[rmsb_pkg::RFS_SRCRT] <= SRC_ADDR_MSB;
            RX_FRAME_STATUS[rmsb_pkg::RFS_EAC +: 3] <= RX_EAC_INDICATORS;
        end
    end

    // ------------------------------------------------
    // Read path
    // ------------------------------------------------
    always_comb begin
        next_rdata = 16'h0000;
        if (REG_RD) begin
            if (REG_ADDR[3:2] == 2'b00) begin
                next_rdata = status[idx];
            end else if (rd_enable) begin
                next_rdata = enable[idx];
            end else begin
                case (REG_ADDR)
                    rmsb_pkg::ADDR_MODE1: next_rdata = mode_one;
                    rmsb_pkg::ADDR_MODE2: next_rdata = mode_two;
                    rmsb_pkg::ADDR_HDATA: next_rdata = host_data_register;
                    rmsb_pkg::ADDR_STATE: begin
                        next_rdata = MAC_STATE;
                        next_rdata[rmsb_pkg::STATE_PEND] = host_request_pending;
                    end
                    default: next_rdata = 16'h0000;
                endcase
            end
        end
    end

    // Clear registers read as zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= 16'h0000;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    err_overflow_a: assert property (
        err_ovf |=> status[3][rmsb_pkg::S2LO_ERRC] && error_event_counter == 16'h0000)
        else $error("error counter overflow not flagged");
    frame_overflow_a: assert property (
        frm_ovf |=> status[3][rmsb_pkg::S2LO_FRMC] && rx_frame_counter == 16'h0000)
        else $error("frame counter overflow not flagged");
    lost_overflow_a: assert property (
        lost_ovf |=> status[3][rmsb_pkg::S2LO_LOST])
        else $error("lost counter overflow not flagged");
    bus_select_a: assert property (
        rx_bus_select [*4] |-> RX_SYMBOL == $past(RX_BUS_A, 3))
        else $error("receive symbol not from bus A");
    late_expiry_a: assert property (
        EVENTS.trt_expired && EVENTS.late_count_nz |=> status[3][rmsb_pkg::S2LO_ROTLATE])
        else $error("late rotation expiry not flagged");
    recovery_expiry_a: assert property (
        EVENTS.trt_expired && TX_STATE == 3'h5 |=> status[3][rmsb_pkg::S2LO_ROTREC])
        else $error("recovery rotation expiry not flagged");
    source_route_a: assert property (
        FRAME_DONE |=> RX_FRAME_STATUS[rmsb_pkg::RFS_SRCRT] == $past(SRC_ADDR_MSB))
        else $error("source routing bit wrong");
    tag_gate_a: assert property (
        !TAG_MODE && !status[0][rmsb_pkg::S1HI_SFULL] |=> !status[0][rmsb_pkg::S1HI_SFULL])
        else $error("buffer full flagged outside tag mode");
    pending_hold_a: assert property (
        host_request_pending && !HDATA_DONE && !hdata_access |=> host_request_pending)
        else $error("pending request dropped early");
    sticky_set_a: assert property (
        status[3][rmsb_pkg::S2LO_RNGOP] && !(wr_clear && idx == 2'h3)
        |=> status[3][rmsb_pkg::S2LO_RNGOP])
        else $error("status flag lost without clear");
    set_wins_a: assert property (
        EVENTS.ring_flags[7] && wr_clear && idx == 2'h3 |=> status[3][rmsb_pkg::S2LO_RNGOP])
        else $error("clear beat a new event");

    overflow_c: cover property (err_ovf ##1 IRQ);
    clear_c: cover property (status[2] != 16'h0000 ##1 wr_clear ##1 status[2] == 16'h0000);
    pending_c: cover property (hdata_access ##1 host_request_pending [*3] ##1 !host_request_pending);
    bus_b_c: cover property (!rx_bus_select && FRAME_DONE);
endmodule // rmsb_bank
`default_nettype wire

// *** rtl/rmsb_pkg.sv ***
// Summary of operation
// - Two 32-bit status registers, 16-bit halves
// - Error counter overflow sets status two low 5
// - Frame counter overflow sets status two low 4
// - Lost counter overflow sets status two low 6
// - Mode bit 2 picks bus A, else B
// - Rotation expiry with late count sets low 10
// - Rotation expiry in T4/T5 sets low 1
// - Source address MSB sets frame status 28
// - Frame status reports E, A, C indicators
// - Claim and beacon flags in status two upper
// - Receive flags in status two upper
// - Ring flags in status two lower
// - Queue lock flags at status one low 0-3
// - Underrun flags at status one low 12-15
// - Tag mode: buffer full flags, transmit abort
// - Chain end 4-7, frame end 0-3, one upper
// - Mode register control bit positions
// - State register bit 3: host request pending
package rmsb_pkg;
    // ------------------------------------------------
    // Register map
    // ------------------------------------------------
    localparam logic [3:0] ADDR_S1HI = 4'h0;
    localparam logic [3:0] ADDR_S1LO = 4'h1;
    localparam logic [3:0] ADDR_S2HI = 4'h2;
    localparam logic [3:0] ADDR_S2LO = 4'h3;
    localparam logic [3:0] ADDR_MODE1 = 4'h4;
    localparam logic [3:0] ADDR_MODE2 = 4'h5;
    localparam logic [3:0] ADDR_STATE = 4'h6;
    localparam logic [3:0] ADDR_HDATA = 4'h7;
    localparam logic [3:0] ADDR_ENABLE_BASE = 4'h8;
    localparam logic [3:0] ADDR_CLEAR_BASE = 4'hc;
    // ------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------
    localparam int S1HI_ABORT = 15;
    localparam int S1HI_SFULL = 10;
    localparam int S1HI_AFULL = 9;
    localparam int S1HI_CHAIN = 4;
    localparam int S1HI_FEND = 0;
    localparam int S1LO_LOCK = 0;
    localparam int S1LO_UNDER = 12;
    localparam int S2HI_RCOMP = 15;
    localparam int S2HI_RMT = 14;
    localparam int S2HI_RABT = 13;
    localparam int S2HI_RFULL = 12;
    localparam int S2HI_ROVR = 11;
    localparam int S2HI_RSNGL = 10;
    localparam int S2HI_RFCOV = 9;
    localparam int S2HI_SFERR = 7;
    localparam int S2HI_MYCLM = 5;
    localparam int S2HI_HICLM = 4;
    localparam int S2HI_LOCLM = 3;
    localparam int S2HI_MYBEC = 1;
    localparam int S2HI_OTBEC = 0;
    localparam int S2LO_RNGOP = 15;
    localparam int S2LO_MULTDA = 14;
    localparam int S2LO_TKERR = 13;
    localparam int S2LO_TKISS = 12;
    localparam int S2LO_VALIDTX = 11;
    localparam int S2LO_ROTLATE = 10;
    localparam int S2LO_MISS = 9;
    localparam int S2LO_PHYINV = 7;
    localparam int S2LO_LOST = 6;
    localparam int S2LO_ERRC = 5;
    localparam int S2LO_FRMC = 4;
    localparam int S2LO_SIFG = 3;
    localparam int S2LO_ROTREC = 1;
    localparam int MODE1_SNGL = 15;
    localparam int MODE1_SHORTA = 11;
    localparam int MODE1_RXSEL = 2;
    localparam int MODE2_SYMBOL_CONTROL_BIT = 5;
    localparam int MODE2_SYNC_HOST_DMA_REQUEST = 6;
    localparam int STATE_PEND = 3;
    localparam int RFS_SRCRT = 28;
    localparam int RFS_EAC = 0;
    localparam logic [15:0] MODE1_RESET = 16'h0004;
    localparam logic [15:0] MODE2_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [2:0] TX_T4 = 3'h4;
    localparam logic [2:0] TX_T5 = 3'h5;
    // ------------------------------------------------
    // Event carrier
    // ------------------------------------------------
    typedef struct packed {
        logic [3:0] tx_frame_end;
        logic [3:0] tx_chain_end;
        logic sync_full;
        logic async_full;
        logic tx_abort;
        logic [3:0] queue_lock;
        logic [3:0] tx_underrun;
        logic [6:0] rx_flags;
        logic [5:0] recovery_flags;
        logic [7:0] ring_flags;
        logic trt_expired;
        logic late_count_nz;
        logic err_event;
        logic rx_frame;
        logic lost_frame;
    } rmsb_event_type;
endpackage

// *** verification/rmsb_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmsb_bank_bench;
    typedef struct {
        logic [3:0] addr;
        rmsb_pkg::rmsb_event_type ev;
        logic [2:0] st;
        logic tag;
        logic [15:0] exp;
    } rmsb_row_type;
    localparam int LIMIT = 80000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] rdata;
    rmsb_pkg::rmsb_event_type events = '0;
    logic [2:0] tx_state = 3'h0;
    logic tag_mode = 1'b0;
    logic [15:0] mac_state = 16'h0000;
    logic hdata_done = 1'b0;
    logic frame_done = 1'b0;
    logic src_msb = 1'b0;
    logic [2:0] eac = 3'h0;
    logic [9:0] bus_a = 10'h2a5;
    logic [9:0] bus_b = 10'h15a;
    logic [31:0] rx_status;
    logic [9:0] rx_symbol;
    logic sngl, short_sel, sym, dma, irq;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    rmsb_row_type rows[$];

    always #4 clk = ~clk;

    rmsb_host_model i_host (.CLK(clk), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata));

    rmsb_bank i_dut (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .EVENTS(events),
        .TX_STATE(tx_state), .TAG_MODE(tag_mode), .MAC_STATE(mac_state),
        .HDATA_DONE(hdata_done), .FRAME_DONE(frame_done), .SRC_ADDR_MSB(src_msb),
        .RX_EAC_INDICATORS(eac), .RX_FRAME_STATUS(rx_status), .RX_BUS_A(bus_a),
        .RX_BUS_B(bus_b), .RX_SYMBOL(rx_symbol), .SINGLE_FRAME_RX_MODE(sngl),
        .SHORT_ADDR_SELECT(short_sel), .SYMBOL_CONTROL_BIT(sym),
        .SYNC_HOST_DMA_REQUEST(dma), .IRQ(irq));

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.rd(a, d);
        check({16'h0000, d}, {16'h0000, exp});
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    task automatic pulse(input rmsb_pkg::rmsb_event_type ev);
        @(posedge clk);
        events <= ev;
        @(posedge clk);
        events <= '0;
    endtask
    task automatic clear_all();
        for (int i = 0; i < 4; i++) begin
            i_host.wr(rmsb_pkg::ADDR_CLEAR_BASE + 4'(i), 16'hffff);
        end
    endtask
    task automatic frame(input logic msb, input logic [2:0] ind);
        @(posedge clk);
        src_msb <= msb;
        eac <= ind;
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        src_msb <= ~msb;
        eac <= ~ind;
    endtask
    task automatic add_row(input logic [3:0] a, input rmsb_pkg::rmsb_event_type ev,
        input logic [2:0] st, input logic tag, input logic [15:0] exp);
        rows.push_back('{a, ev, st, tag, exp});
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        add_row(4'h0, '{tx_frame_end: 4'h9, tx_chain_end: 4'h6, default: '0}, 3'h0, 1'b0,
            16'h0069);
        add_row(4'h0, '{sync_full: 1'b1, async_full: 1'b1, tx_abort: 1'b1, default: '0},
            3'h0, 1'b1, 16'h8600);
        add_row(4'h0, '{sync_full: 1'b1, async_full: 1'b1, tx_abort: 1'b1, default: '0},
            3'h0, 1'b0, 16'h0000);
        add_row(4'h1, '{queue_lock: 4'h9, tx_underrun: 4'h6, default: '0}, 3'h0, 1'b0,
            16'h6009);
        add_row(4'h2, '{rx_flags: 7'h55, recovery_flags: 6'h2a, default: '0}, 3'h0, 1'b0,
            16'haa92);
        add_row(4'h2, '{rx_flags: 7'h2a, recovery_flags: 6'h15, default: '0}, 3'h0, 1'b0,
            16'h5429);
        add_row(4'h3, '{ring_flags: 8'haa, default: '0}, 3'h0, 1'b0, 16'ha880);
        add_row(4'h3, '{ring_flags: 8'h55, default: '0}, 3'h0, 1'b0, 16'h5208);
        add_row(4'h3, '{trt_expired: 1'b1, late_count_nz: 1'b1, default: '0}, 3'h0, 1'b0,
            16'h0400);
        add_row(4'h3, '{trt_expired: 1'b1, default: '0}, 3'h4, 1'b0, 16'h0002);
        add_row(4'h3, '{trt_expired: 1'b1, default: '0}, 3'h5, 1'b0, 16'h0002);
        add_row(4'h3, '{trt_expired: 1'b1, default: '0}, 3'h3, 1'b0, 16'h0000);
        add_row(4'h3, '{late_count_nz: 1'b1, default: '0}, 3'h4, 1'b0, 16'h0000);
        add_row(4'h1, '{ring_flags: 8'hff, rx_flags: 7'h7f, default: '0}, 3'h0, 1'b0,
            16'h0000);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_check(rmsb_pkg::ADDR_MODE1, 16'h0004);
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h0000);
        foreach (rows[i]) begin
            clear_all();
            tx_state <= rows[i].st;
            tag_mode <= rows[i].tag;
            pulse(rows[i].ev);
            rd_check(rows[i].addr, rows[i].exp);
        end
        // Sticky flag, interrupt enable and clear
        clear_all();
        pulse('{ring_flags: 8'h80, default: '0});
        repeat (3) settle();
        check({31'h0, irq}, 32'h0);
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h8000);
        i_host.wr(rmsb_pkg::ADDR_ENABLE_BASE + 4'h3, 16'h8000);
        settle();
        check({31'h0, irq}, 32'h1);
        i_host.wr(rmsb_pkg::ADDR_S2LO, 16'h0000);
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h8000);
        i_host.wr(rmsb_pkg::ADDR_CLEAR_BASE + 4'h3, 16'h8000);
        settle();
        check({31'h0, irq}, 32'h0);
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h0000);
        rd_check(rmsb_pkg::ADDR_CLEAR_BASE, 16'h0000);
        // Mode bits and receive bus select
        repeat (4) settle();
        check({22'h0, rx_symbol}, 32'h2a5);
        i_host.wr(rmsb_pkg::ADDR_MODE1, 16'h8000);
        repeat (4) settle();
        check({22'h0, rx_symbol}, 32'h15a);
        check({30'h0, sngl, short_sel}, 32'h2);
        i_host.wr(rmsb_pkg::ADDR_MODE1, 16'h0804);
        repeat (4) settle();
        check({22'h0, rx_symbol}, 32'h2a5);
        check({30'h0, sngl, short_sel}, 32'h1);
        rd_check(rmsb_pkg::ADDR_MODE1, 16'h0804);
        i_host.wr(rmsb_pkg::ADDR_MODE2, 16'h0020);
        settle();
        check({30'h0, sym, dma}, 32'h2);
        i_host.wr(rmsb_pkg::ADDR_MODE2, 16'h0040);
        settle();
        check({30'h0, sym, dma}, 32'h1);
        // Receive frame status word
        frame(1'b1, 3'b101);
        repeat (3) settle();
        check(rx_status, 32'h1000_0005);
        frame(1'b0, 3'b010);
        settle();
        check(rx_status, 32'h0000_0002);
        // Host data request pending
        @(posedge clk);
        mac_state <= 16'h00fc;
        rd_check(rmsb_pkg::ADDR_STATE, 16'h00f4);
        i_host.wr(rmsb_pkg::ADDR_HDATA, 16'h1234);
        rd_check(rmsb_pkg::ADDR_STATE, 16'h00fc);
        @(posedge clk);
        hdata_done <= 1'b1;
        @(posedge clk);
        hdata_done <= 1'b0;
        rd_check(rmsb_pkg::ADDR_STATE, 16'h00f4);
        // Counter overflow at the 16-bit boundary
        clear_all();
        @(posedge clk);
        events <= '{err_event: 1'b1, rx_frame: 1'b1, lost_frame: 1'b1, default: '0};
        repeat (65535) @(posedge clk);
        events <= '0;
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h0000);
        pulse('{err_event: 1'b1, rx_frame: 1'b1, lost_frame: 1'b1, default: '0});
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h0070);
        // Reset in mid-run wipes flags and enables and returns mode one to its reset value
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd_check(rmsb_pkg::ADDR_S2LO, 16'h0000);
        rd_check(rmsb_pkg::ADDR_ENABLE_BASE + 4'h3, 16'h0000);
        rd_check(rmsb_pkg::ADDR_MODE1, 16'h0004);
        tally_and_finish();
    end
endmodule // rmsb_bank_bench
`default_nettype wire

// *** verification/rmsb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmsb_host_model (
    // Clock
    input wire logic CLK,
    // Register port
    output logic [3:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire logic [15:0] REG_RDATA
);
    initial begin
        REG_ADDR = 4'h0;
        REG_WDATA = 16'h0000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end
    // Released lines flip, so a stale value never looks valid
    task automatic release_bus();
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
        REG_ADDR <= ~REG_ADDR;
        REG_WDATA <= ~REG_WDATA;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        release_bus();
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        release_bus();
        #1;
        d = REG_RDATA;
    endtask
endmodule // rmsb_host_model
`default_nettype wire
